// ==== design/smz_ctrl.sv ====
// mode decode, servo-off stop sequencing and zero clamp gating
// assumes contact inputs are active low and synchronous to pclk
`default_nettype none
module smz_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic servo_on_n,
  input wire logic alarm,
  input wire logic power_lost,
  input wire logic speed_select_a_input,
  input wire logic speed_select_b_input,
  input wire logic multi_function_contact,
  input wire logic [13:0] speed_ref,
  input wire logic [13:0] motor_speed,
  input wire logic signed [1:0] clamp_err,
  output smz_pkg::smz_drive_s drive,
  output logic clamp_correct,
  output logic clamp_dir
);
  // control registers
  logic [3:0] mode_q;
  logic [1:0] stop_sel_q;
  logic zc_alloc_q;
  logic [13:0] hold_q;
  logic [13:0] max_q;
  logic [1:0] latched_stop_q;
  smz_pkg::smz_stop_e st_q, st_d;
  smz_pkg::smz_drive_s drive_d;
  logic [31:0] rdata_d;

  // apb decode; zero-wait so pready is a registered constant high
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && !penable && !pwrite;
  wire hit = paddr == smz_pkg::OFF_CTRL || paddr == smz_pkg::OFF_HOLD || paddr == smz_pkg::OFF_STAT
    || paddr == smz_pkg::OFF_SPD || paddr == smz_pkg::OFF_MAX;

  function automatic logic [13:0] sat_hold(input logic [31:0] v);
    sat_hold = (v > 32'(smz_pkg::HOLD_MAX)) ? smz_pkg::HOLD_MAX : v[13:0];
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= smz_pkg::MODE_RST;
      stop_sel_q <= smz_pkg::STOP_RST;
      zc_alloc_q <= 1'b0;
      hold_q <= smz_pkg::HOLD_RST;
      max_q <= smz_pkg::MAX_RST;
    end
    else if (wr_en && paddr == smz_pkg::OFF_CTRL)
    begin
      mode_q <= pwdata[smz_pkg::CTRL_MODE_LSB +: 4];
      stop_sel_q <= pwdata[smz_pkg::CTRL_STOP_LSB +: 2];
      zc_alloc_q <= pwdata[smz_pkg::CTRL_ZC_ALLOC_BIT];
    end
    else if (wr_en && paddr == smz_pkg::OFF_HOLD)
      hold_q <= sat_hold(pwdata);
    else if (wr_en && paddr == smz_pkg::OFF_MAX)
      max_q <= pwdata[13:0];
  end

  // read mux, registered so prdata comes from a flop
  always_comb
  begin
    rdata_d = 32'h0;
    unique case (paddr)
      smz_pkg::OFF_CTRL: rdata_d = {23'h0, zc_alloc_q, 2'h0, stop_sel_q, mode_q};
      smz_pkg::OFF_HOLD: rdata_d = {18'h0, hold_q};
      smz_pkg::OFF_STAT: rdata_d = {23'h0, latched_stop_q, st_q, drive.loop};
      smz_pkg::OFF_SPD: rdata_d = {18'h0, motor_speed};
      smz_pkg::OFF_MAX: rdata_d = {18'h0, max_q};
      default: rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (rd_en)
        prdata <= rdata_d;
      pslverr <= psel && !penable && !hit; // answered in the following access cycle
    end
  end

  // servo-off cause and effective hold level
  wire off_req = servo_on_n || alarm || power_lost;
  wire [13:0] eff_hold = (hold_q > max_q) ? max_q : hold_q;
  wire slow = motor_speed < smz_pkg::LOW_SPD;
  wire stopped = motor_speed == 14'h0;
  wire zc_in_on = !multi_function_contact;

  // zero clamp gating
  wire zc_mode = (mode_q == smz_pkg::CM_HOLD_AT_ZERO_INPUT) || (mode_q == smz_pkg::CM_SPD && zc_alloc_q);
  wire zc_act = zc_mode && zc_in_on && (speed_ref < eff_hold);

  // loop selection; unused codes give no loop
  smz_pkg::smz_loop_e loop_w;
  always_comb
  begin
    loop_w = smz_pkg::SMZ_LOOP_NONE;
    unique case (mode_q)
      smz_pkg::CM_SPD: loop_w = smz_pkg::SMZ_LOOP_ANA_SPD;
      smz_pkg::CM_TRQ: loop_w = smz_pkg::SMZ_LOOP_TORQUE;
      smz_pkg::CM_CONTACT: loop_w = smz_pkg::SMZ_LOOP_PRESET;
      smz_pkg::CM_CONT_ANA: loop_w = (speed_select_a_input && speed_select_b_input)
        ? smz_pkg::SMZ_LOOP_ANA_SPD : smz_pkg::SMZ_LOOP_PRESET;
      smz_pkg::CM_TRQ_SPD: loop_w = multi_function_contact
        ? smz_pkg::SMZ_LOOP_ANA_SPD : smz_pkg::SMZ_LOOP_TORQUE;
      smz_pkg::CM_HOLD_AT_ZERO_INPUT: loop_w = smz_pkg::SMZ_LOOP_ANA_SPD;
      smz_pkg::CM_PULSE_INH: loop_w = smz_pkg::SMZ_LOOP_POS;
      smz_pkg::CM_PULSE: loop_w = smz_pkg::SMZ_LOOP_POS;
      smz_pkg::CM_SERIAL: loop_w = smz_pkg::SMZ_LOOP_SERIAL;
      default: loop_w = smz_pkg::SMZ_LOOP_NONE;
    endcase
  end

  // stop sequence next state
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      smz_pkg::SMZ_RUN:
        if (off_req)
          st_d = (slow || stop_sel_q == 2'h2) ? smz_pkg::SMZ_COAST : smz_pkg::SMZ_BRAKE;
      smz_pkg::SMZ_BRAKE:
        if (stopped)
          st_d = (latched_stop_q == 2'h0) ? smz_pkg::SMZ_HELD : smz_pkg::SMZ_COAST;
      smz_pkg::SMZ_HELD, smz_pkg::SMZ_COAST:
        if (!off_req)
          st_d = smz_pkg::SMZ_RUN;
      default: st_d = smz_pkg::SMZ_RUN;
    endcase
  end

  // output composition, registered below
  always_comb
  begin
    drive_d.energised = st_q == smz_pkg::SMZ_RUN && !off_req;
    drive_d.loop = drive_d.energised ? loop_w : smz_pkg::SMZ_LOOP_NONE;
    drive_d.pulse_accept = drive_d.energised && (mode_q == smz_pkg::CM_PULSE
      || (mode_q == smz_pkg::CM_PULSE_INH && multi_function_contact));
    drive_d.hold_at_zero_input = drive_d.energised && zc_act;
    drive_d.brake = st_d == smz_pkg::SMZ_BRAKE || st_d == smz_pkg::SMZ_HELD;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= smz_pkg::SMZ_COAST;
      latched_stop_q <= smz_pkg::STOP_RST;
      drive <= '0;
      clamp_correct <= 1'b0;
      clamp_dir <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (st_q == smz_pkg::SMZ_RUN && off_req)
        latched_stop_q <= stop_sel_q;
      drive <= drive_d;
      // hold within one pulse: correct only when error leaves the +-1 band
      clamp_correct <= drive_d.hold_at_zero_input && (clamp_err == 2'sb10);
      clamp_dir <= clamp_err[1];
    end
  end

  // assertions
  property p_unused_no_loop;
    @(posedge pclk) disable iff (!presetn)
    (mode_q == 4'h5 || mode_q == 4'h8) |=> drive.loop == smz_pkg::SMZ_LOOP_NONE;
  endproperty
  a_unused_no_loop: assert property (p_unused_no_loop) else $error("unused mode ran a loop");

  property p_off_deenergise;
    @(posedge pclk) disable iff (!presetn)
    off_req |=> !drive.energised;
  endproperty
  a_off_deenergise: assert property (p_off_deenergise) else $error("energised during servo-off");

  property p_coast_no_brake;
    @(posedge pclk) disable iff (!presetn)
    (st_q == smz_pkg::SMZ_RUN && off_req && stop_sel_q == 2'h2) |=> !drive.brake;
  endproperty
  a_coast_no_brake: assert property (p_coast_no_brake) else $error("brake in coast mode");

  property p_slow_coast;
    @(posedge pclk) disable iff (!presetn)
    (st_q == smz_pkg::SMZ_RUN && off_req && slow) |=> st_q == smz_pkg::SMZ_COAST;
  endproperty
  a_slow_coast: assert property (p_slow_coast) else $error("braked at low speed");

  property p_held_keeps;
    @(posedge pclk) disable iff (!presetn)
    (st_q == smz_pkg::SMZ_HELD && off_req) |-> latched_stop_q == 2'h0 ##1 drive.brake;
  endproperty
  a_held_keeps: assert property (p_held_keeps) else $error("held brake released");

  property p_release_after_stop;
    @(posedge pclk) disable iff (!presetn)
    (st_q == smz_pkg::SMZ_BRAKE && stopped && latched_stop_q == 2'h1) |=> !drive.brake;
  endproperty
  a_release_after_stop: assert property (p_release_after_stop) else $error("brake kept in mode 1");

  property p_zc_needs_input;
    @(posedge pclk) disable iff (!presetn)
    multi_function_contact |=> !drive.hold_at_zero_input;
  endproperty
  a_zc_needs_input: assert property (p_zc_needs_input) else $error("clamp with input open");

  property p_zc_level;
    @(posedge pclk) disable iff (!presetn)
    (speed_ref >= eff_hold) |=> !drive.hold_at_zero_input;
  endproperty
  a_zc_level: assert property (p_zc_level) else $error("clamp above hold level");

  property p_inhibit;
    @(posedge pclk) disable iff (!presetn)
    (mode_q == smz_pkg::CM_PULSE_INH && !multi_function_contact) |=> !drive.pulse_accept;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("pulses taken while inhibited");

  property p_mode4_analog;
    @(posedge pclk) disable iff (!presetn)
    (mode_q == smz_pkg::CM_CONT_ANA && !off_req && st_q == smz_pkg::SMZ_RUN
      && speed_select_a_input && speed_select_b_input) |=> drive.loop == smz_pkg::SMZ_LOOP_ANA_SPD;
  endproperty
  a_mode4_analog: assert property (p_mode4_analog) else $error("mode 4 not analog");

  property p_mode9_torque;
    @(posedge pclk) disable iff (!presetn)
    (mode_q == smz_pkg::CM_TRQ_SPD && st_q == smz_pkg::SMZ_RUN && !off_req && !multi_function_contact)
      |=> drive.loop == smz_pkg::SMZ_LOOP_TORQUE;
  endproperty
  a_mode9_torque: assert property (p_mode9_torque) else $error("mode 9 torque not selected");

  property p_mode9_speed;
    @(posedge pclk) disable iff (!presetn)
    (mode_q == smz_pkg::CM_TRQ_SPD && st_q == smz_pkg::SMZ_RUN && !off_req && multi_function_contact)
      |=> drive.loop == smz_pkg::SMZ_LOOP_ANA_SPD;
  endproperty
  a_mode9_speed: assert property (p_mode9_speed) else $error("mode 9 speed not selected");

  property p_serial_loop;
    @(posedge pclk) disable iff (!presetn)
    (mode_q == smz_pkg::CM_SERIAL && st_q == smz_pkg::SMZ_RUN && !off_req)
      |=> drive.loop == smz_pkg::SMZ_LOOP_SERIAL;
  endproperty
  a_serial_loop: assert property (p_serial_loop) else $error("mode d not serial");

  property p_pulse_only;
    @(posedge pclk) disable iff (!presetn)
    (mode_q == smz_pkg::CM_PULSE && st_q == smz_pkg::SMZ_RUN && !off_req)
      |=> drive.pulse_accept && drive.loop == smz_pkg::SMZ_LOOP_POS;
  endproperty
  a_pulse_only: assert property (p_pulse_only) else $error("mode c pulses refused");

  property p_zc_on;
    @(posedge pclk) disable iff (!presetn)
    (st_q == smz_pkg::SMZ_RUN && !off_req && zc_act) |=> drive.hold_at_zero_input;
  endproperty
  a_zc_on: assert property (p_zc_on) else $error("clamp not applied");

  property p_stop_latch;
    @(posedge pclk) disable iff (!presetn)
    (st_q == smz_pkg::SMZ_RUN && off_req) |=> latched_stop_q == $past(stop_sel_q);
  endproperty
  a_stop_latch: assert property (p_stop_latch) else $error("stop mode not latched");

  // stop 0: braking ends in the held state with the brake still on
  sequence s_brake_done_keep;
    st_q == smz_pkg::SMZ_BRAKE && stopped && latched_stop_q == 2'h0;
  endsequence
  sequence s_held_on;
    st_q == smz_pkg::SMZ_HELD ##0 drive.brake;
  endsequence

  property p_brake_to_held;
    @(posedge pclk) disable iff (!presetn)
    s_brake_done_keep |=> s_held_on;
  endproperty
  a_brake_to_held: assert property (p_brake_to_held) else $error("brake dropped after stop");
endmodule
`default_nettype wire

// ==== design/smz_pkg.sv ====
// package for the servo mode, stop and zero-clamp block
// assumes a single pclk domain and apb software access
`default_nettype none
package smz_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_HOLD = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_SPD = 12'h00c;
  localparam logic [11:0] OFF_MAX = 12'h010;
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_STOP_LSB = 4;
  localparam int CTRL_ZC_ALLOC_BIT = 8;
  // reset values, hold saturation limit and low speed threshold
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] STOP_RST = 2'h0;
  localparam logic [13:0] HOLD_RST = 14'h000a;
  localparam logic [13:0] HOLD_MAX = 14'h2710;
  localparam logic [13:0] MAX_RST = 14'h1770;
  localparam logic [13:0] LOW_SPD = 14'h0002;
  // control method codes
  localparam logic [3:0] CM_SPD = 4'h0;
  localparam logic [3:0] CM_TRQ = 4'h2;
  localparam logic [3:0] CM_CONTACT = 4'h3;
  localparam logic [3:0] CM_CONT_ANA = 4'h4;
  localparam logic [3:0] CM_TRQ_SPD = 4'h9;
  localparam logic [3:0] CM_HOLD_AT_ZERO_INPUT = 4'ha;
  localparam logic [3:0] CM_PULSE_INH = 4'hb;
  localparam logic [3:0] CM_PULSE = 4'hc;
  localparam logic [3:0] CM_SERIAL = 4'hd;
  // active loop encoding
  typedef enum logic [2:0] {
    SMZ_LOOP_NONE = 3'h0,
    SMZ_LOOP_ANA_SPD = 3'h1,
    SMZ_LOOP_PRESET = 3'h2,
    SMZ_LOOP_TORQUE = 3'h3,
    SMZ_LOOP_POS = 3'h4,
    SMZ_LOOP_SERIAL = 3'h5
  } smz_loop_e;
  // stop sequence states, one-hot
  typedef enum logic [3:0] {
    SMZ_RUN = 4'h1,
    SMZ_BRAKE = 4'h2,
    SMZ_HELD = 4'h4,
    SMZ_COAST = 4'h8
  } smz_stop_e;
  // drive outputs travelling together
  typedef struct packed {
    logic [2:0] loop;
    logic pulse_accept;
    logic hold_at_zero_input;
    logic energised;
    logic brake;
  } smz_drive_s;
endpackage
`default_nettype wire

// ==== tb/smz_host.sv ====
// host model: contact inputs, speed reference and feedback
// assumes the bench calls put() from its clocked flow
`default_nettype none
module smz_host (
  input wire logic pclk,
  output logic [5:0] ct,
  output logic [13:0] ref_q,
  output logic [13:0] spd_q,
  output logic signed [1:0] err_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ct is {servo off, alarm, power lost, sel a, sel b, multi}
  task automatic put(input logic [5:0] c, input logic [13:0] r, input logic [13:0] s, input logic [1:0] e);
    @(posedge pclk);
    ct <= c;
    ref_q <= r;
    spd_q <= s;
    err_q <= e;
  endtask
  // idle host: servo off request, contacts open
  initial
  begin
    ct = 6'h27;
    ref_q = 14'h0;
    spd_q = 14'h0;
    err_q = 2'h0;
  end
endmodule
`default_nettype wire

// ==== tb/smz_ctrl_test.sv ====
// self-checking bench for the mode, stop and zero clamp block
// assumes smz_pkg and smz_ctrl are compiled first
`default_nettype none
module smz_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clamp_correct, clamp_dir;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr_q;
  logic [5:0] ct;
  logic [13:0] sref, mspd;
  logic signed [1:0] cerr;
  logic [8:0] tbl [11] = '{9'h0, 9'h100, 9'h2, 9'h3, 9'h4, 9'h5, 9'h9, 9'ha, 9'hb, 9'hc, 9'hd};
  smz_pkg::smz_drive_s drive;
  int bad_count, total_checks;
  smz_host host (.pclk(pclk), .ct(ct), .ref_q(sref), .spd_q(mspd), .err_q(cerr));
  smz_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .servo_on_n(ct[5]), .alarm(ct[4]), .power_lost(ct[3]), .speed_select_a_input(ct[2]),
    .speed_select_b_input(ct[1]), .multi_function_contact(ct[0]), .speed_ref(sref),
    .motor_speed(mspd), .clamp_err(cerr), .drive(drive), .clamp_correct(clamp_correct),
    .clamp_dir(clamp_dir));
  // 100 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // reference model of the selected loop
  function automatic logic [2:0] exp_loop(input logic [3:0] m, input logic [5:0] c);
    case (m)
      4'h0, 4'ha: return 3'h1;
      4'h2: return 3'h3;
      4'h3: return 3'h2;
      4'h4: return (c[2] && c[1]) ? 3'h1 : 3'h2;
      4'h9: return c[0] ? 3'h1 : 3'h3;
      4'hb, 4'hc: return 3'h4;
      4'hd: return 3'h5;
      default: return 3'h0;
    endcase
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, x, g);
    end
  endtask
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    if (!xe)
      chk(s, x, q);
    chk(s, {31'h0, xe}, {31'h0, e});
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask
  // main sequence: registers, mode table, stop sequences
  initial
  begin
    logic [5:0] c;
    logic zc;
    bad_count = 0;
    total_checks = 0;
    lfsr_q = 32'h835c;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", 12'h000, 32'h0, 1'b0);
    rdc("hold", 12'h004, 32'ha, 1'b0);
    rdc("unmapped", 12'h0f0, 32'h0, 1'b1);
    wr(12'h004, 32'h2ee0);
    rdc("hold sat", 12'h004, 32'h2710, 1'b0);
    wr(12'h004, 32'ha);
    wr(12'h010, 32'h5);
    foreach (tbl[i])
      for (int k = 0; k < 8; k++)
      begin
        lfsr_q = lfsr(lfsr_q);
        c = {3'b000, k[2:0]};
        wr(12'h000, {23'h0, tbl[i]});
        host.put(c, 14'(lfsr_q % 20), 14'h0, lfsr_q[9:8]);
        settle();
        // motor maximum 5 sits below the hold level 10, so it sets the clamp level
        zc = (tbl[i][3:0] == 4'ha || tbl[i] == 9'h100) && !c[0] && sref < 14'h5;
        chk("loop", {29'h0, exp_loop(tbl[i][3:0], c)}, {29'h0, drive.loop});
        chk("hold_at_zero_input", {31'h0, zc}, {31'h0, drive.hold_at_zero_input});
        chk("correct", {31'h0, zc && cerr == -2'sd2}, {31'h0, clamp_correct});
        chk("dir", {31'h0, cerr[1]}, {31'h0, clamp_dir});
        if (tbl[i][3:0] == 4'hb || tbl[i][3:0] == 4'hc)
          chk("pulse", {31'h0, tbl[i][3:0] == 4'hc || c[0]}, {31'h0, drive.pulse_accept});
      end
    for (int k = 0; k < 6; k++)
    begin
      c = (k % 3 == 0) ? 6'h27 : (k % 3 == 1) ? 6'h17 : 6'h0f;
      wr(12'h000, {26'h0, 2'(k % 3), 4'h0});
      host.put(6'h07, 14'h0, (k < 3) ? 14'd100 : 14'd1, 2'h0);
      settle();
      chk("run", 32'h1, {31'h0, drive.energised});
      host.put(c, 14'h0, (k < 3) ? 14'd100 : 14'd1, 2'h0);
      settle();
      chk("off", 32'h0, {31'h0, drive.energised});
      chk("braking", {31'h0, k < 2}, {31'h0, drive.brake});
      wr(12'h000, 32'h20);
      host.put(c, 14'h0, 14'h0, 2'h0);
      settle();
      chk("stopped", {31'h0, k == 0}, {31'h0, drive.brake});
    end
    results();
  end
endmodule
`default_nettype wire
